// >>> sim/crws_core_read_seq_bench.sv
// Self-checking bench for the core read word sequencer
`timescale 1ns/1ps
module crws_core_read_seq_bench;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, read_start_i = 1'b0;
    logic        start_by_processor_i = 1'b0, use_single_word_i = 1'b0, processor_sync_strobe_i = 1'b0;
    logic        go = 1'b0, use_b = 1'b0, link_clk_i, word_valid_a_i, word_valid_b_i, mdone;
    logic [3:0]  reg_addr_i = 4'h0, buffer_drained_i = 4'h0, buffer_load_o, buffer_pending_queue_o;
    logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o, d;
    logic [0:3]  read_invalid_words_i = 4'h0, read_single_word_i = 4'h0, mem_request_lines_o;
    logic [1:0]  physical_word_bits_i = 2'h0, mem_low_addr_o, cache_buffer_index_o;
    logic        read_in_progress_o, init_done_o, core_busy_o, cache_write_data_ready_o, first_word_delay_one_o;
    logic        first_word_delay_two_o, first_parity_en_o, memory_to_cache_mux_o, first_cache_write_o;
    logic        cache_buffer_cycle_o;
    logic [1:0]  q[$], e[$];
    int          bad_count = 0, total_checks = 0, cyc = 0, n;
    // ****************************************************************
    // Design, memory model, clock and side monitor
    // ****************************************************************
    crws_core_read_seq crws_core_read_seq_inst (.*);
    crws_mem_model crws_mem_model_inst (.go_i(go), .use_b_i(use_b), .req_i(mem_request_lines_o),
        .addr_i(mem_low_addr_o), .link_clk_o(link_clk_i), .valid_a_o(word_valid_a_i),
        .valid_b_o(word_valid_b_i), .done_o(mdone));
    always #20 clk_sys_i = ~clk_sys_i;
    // Processor takes the first word late; buffers drain right after load
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        processor_sync_strobe_i <= first_word_delay_two_o;
        buffer_drained_i <= buffer_load_o;
        for (int i = 0; i < 4; i++)
            if (buffer_load_o[i] === 1'b1) q.push_back(i[1:0]);
        if (cyc == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // Waits: 0 read in progress, 1 memory done, 2 core idle
    task wt(input int sel);
        n = 0;
        while (n < 300 && (sel == 0 ? read_in_progress_o !== 1'b1 : sel == 1 ? mdone !== 1'b1 : core_busy_o !== 1'b0))
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
    endtask
    // Unused pattern source gets the inverse so a wrong pick shows
    task start(input logic p, input logic s, input logic [0:3] pat, input logic [1:0] pb);
        @(posedge clk_sys_i);
        read_start_i <= 1'b1;
        start_by_processor_i <= p;
        use_single_word_i <= s;
        read_invalid_words_i <= s ? ~pat : pat;
        read_single_word_i <= s ? pat : ~pat;
        physical_word_bits_i <= pb;
        @(posedge clk_sys_i);
        read_start_i <= 1'b0;
    endtask
    task run(input logic p, s, b, input logic [0:3] pat, input logic [1:0] pb, st, input logic [0:3] sr);
        logic [1:0] w;
        use_b <= b;
        start(p, s, pat, pb);
        #1 chk(mem_request_lines_o, pat);
        chk(mem_low_addr_o, st);
        wt(0);
        rd(4'h4);
        chk(d[11:8], sr);
        chk(d[5:4], st);
        q.delete();
        e.delete();
        go <= 1'b1;
        wt(1);
        go <= 1'b0;
        wt(2);
        for (int k = 0; k < 4; k++)
        begin
            w = st + k[1:0];
            if (pat[w]) e.push_back(w);
        end
        chk(q.size(), e.size());
        foreach (e[i]) chk(q[i], e[i]);
        chk(buffer_pending_queue_o, 4'h0);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(4'h4);
        chk(d, 32'h00000000);
        rd(4'h0);
        chk(d, 32'h00000001);
        rd(4'h8);
        chk(d, 32'h00000000);
        wr(4'h0, 32'h00000000);
        start(1'b0, 1'b0, 4'b1000, 2'b00);
        repeat (20) @(posedge clk_sys_i);
        chk(read_in_progress_o, 1'b0);
        chk(mem_request_lines_o, 4'h0);
        wr(4'h8, 32'hFFFFFFFF);
        wr(4'h0, 32'h00000001);
        rd(4'h0);
        chk(d, 32'h00000001);
        run(1'b1, 1'b0, 1'b0, 4'b1100, 2'b01, 2'b01, 4'b1001);
        run(1'b1, 1'b0, 1'b1, 4'b1011, 2'b11, 2'b11, 4'b1101);
        run(1'b0, 1'b0, 1'b0, 4'b1010, 2'b11, 2'b00, 4'b1010);
        run(1'b0, 1'b0, 1'b1, 4'b0110, 2'b00, 2'b01, 4'b1100);
        run(1'b0, 1'b1, 1'b0, 4'b0011, 2'b00, 2'b10, 4'b1100);
        run(1'b0, 1'b0, 1'b0, 4'b0001, 2'b00, 2'b11, 4'b1000);
        conclude();
    end
endmodule

// >>> sim/crws_core_read_seq_properties.sv
// Port-level assertions for the core read word sequencer
`timescale 1ns/1ps
module crws_core_read_seq_properties
(
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic [3:0] buffer_load_o,
    input wire logic [3:0] buffer_pending_queue_o,
    input wire logic       read_in_progress_o,
    input wire logic       init_done_o,
    input wire logic       core_busy_o,
    input wire logic       cache_write_data_ready_o,
    input wire logic       first_word_delay_one_o,
    input wire logic       first_word_delay_two_o,
    input wire logic       first_parity_en_o,
    input wire logic       memory_to_cache_mux_o,
    input wire logic       first_cache_write_o,
    input wire logic       processor_sync_strobe_i,
    input wire logic       cache_buffer_cycle_o,
    input wire logic [1:0] cache_buffer_index_o
);
    // ****************************************************************
    // Sequencing checks, one clock domain
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    load_onehot_a: assert property ((|buffer_load_o) |-> $onehot(buffer_load_o))
        else $error("buffer load not one-hot");
    pend_before_load_a: assert property ((|buffer_load_o) |-> |(buffer_pending_queue_o & buffer_load_o))
        else $error("buffer loaded without pending entry");
    first_states_a: assert property (cache_write_data_ready_o |=> first_word_delay_one_o ##1 first_word_delay_two_o)
        else $error("first-word states out of order");
    ready_at_load_a: assert property (cache_write_data_ready_o |-> ($past(buffer_load_o) != 4'h0) && !cache_buffer_cycle_o)
        else $error("first-word state without load");
    parity_window_a: assert property (first_parity_en_o == (cache_write_data_ready_o || first_word_delay_one_o
        || first_word_delay_two_o) && memory_to_cache_mux_o == first_parity_en_o)
        else $error("parity window wrong");
    cache_after_take_a: assert property (first_cache_write_o |-> $past(processor_sync_strobe_i))
        else $error("first word written before taken");
    buffer_cycle_a: assert property (cache_buffer_cycle_o |-> $past(buffer_load_o) == (4'h1 << cache_buffer_index_o))
        else $error("cache buffer cycle on wrong buffer");
    busy_hold_a: assert property ((read_in_progress_o || (|buffer_pending_queue_o)) |=> core_busy_o)
        else $error("busy dropped early");
    init_done_a: assert property ($rose(read_in_progress_o) |-> init_done_o)
        else $error("read in progress without init done");
    strobe_gate_a: assert property ((|buffer_load_o) |-> $past(read_in_progress_o, 2))
        else $error("load without read in progress");
endmodule
bind crws_core_read_seq crws_core_read_seq_properties crws_core_read_seq_properties_inst (.*);

// >>> sim/crws_mem_model.sv
// Behavioural core memory answering on the two data-valid strobes
`timescale 1ns/1ps
// ****************************************************************
// Core memory model
// ****************************************************************
module crws_mem_model
(
    input  wire logic       go_i,
    input  wire logic       use_b_i,
    input  wire logic [0:3] req_i,
    input  wire logic [1:0] addr_i,
    output logic            link_clk_o,
    output logic            valid_a_o,
    output logic            valid_b_o,
    output logic            done_o
);
    logic [1:0] w;
    int         k;
    initial
    begin
        link_clk_o = 1'b0;
        valid_a_o  = 1'b0;
        valid_b_o  = 1'b0;
        done_o     = 1'b0;
    end
    // Bus clock stands still between reads
    always #160 if (go_i) link_clk_o = ~link_clk_o;
    // One strobe per placed word, a whole link period wide
    always @(posedge go_i)
    begin
        for (k = 0; k < 4; k++)
        begin
            w = addr_i + k[1:0];
            if (req_i[w] && use_b_i)
            begin
                @(posedge link_clk_o) valid_b_o = 1'b1;
                @(posedge link_clk_o) valid_b_o = 1'b0;
            end
            else if (req_i[w])
            begin
                @(negedge link_clk_o) valid_a_o = 1'b1;
                @(negedge link_clk_o) valid_a_o = 1'b0;
            end
        end
        @(negedge link_clk_o) done_o = 1'b1;
        @(negedge go_i) done_o = 1'b0;
    end
endmodule

// >>> verilog/crws_core_read_seq.sv
// Core read word sequencer: request tracking, buffer steering and first-word delivery
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "crws_params.svh"

// Notes on behaviour
// - Start loads request pattern and word index
// - Request tracker shifts; index counts up/down
// - Latch pattern and start bits onto bus
// - Pattern from invalid-words or single-word request
// - Processor start takes physical word bits
// - Other starts: first requested word ascending
// - Init: decrement index, rotate tracker left
// - Index zero: done, in-progress, reload index
// - Then index increments, strobes shift without rotate
// - Leading zeros shifted out, index follows
// - Last request at top plus strobe ends read
// - Busy until every buffer drained
// - Two delay ticks after strobe before load
// - Load state: index picks buffer, shift, increment
// - Pending entry set one tick before load
// - First processor word runs three extra states
// - Parity check enabled during first-word states
// - Processor takes word, then cache write
// - Other words start a cache buffer cycle

module crws_core_read_seq
    import crws_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    // Register port
    input  wire logic [`CRWS_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [`CRWS_DATA_W-1:0]  reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [`CRWS_DATA_W-1:0]  reg_rdata_o,
    // Cache and channel control side
    input  wire logic                     read_start_i,
    input  wire logic                     start_by_processor_i,
    input  wire logic                     use_single_word_i,
    input  wire logic [0:3]               read_invalid_words_i,
    input  wire logic [0:3]               read_single_word_i,
    input  wire logic [1:0]               physical_word_bits_i,
    input  wire logic                     processor_sync_strobe_i,
    input  wire logic [3:0]               buffer_drained_i,
    // Memory bus side, asynchronous to clk_sys_i
    input  wire logic                     link_clk_i,
    input  wire logic                     word_valid_a_i,
    input  wire logic                     word_valid_b_i,
    output logic      [0:3]               mem_request_lines_o,
    output logic      [1:0]               mem_low_addr_o,
    // Buffer and cache steering
    output logic      [3:0]               buffer_load_o,
    output logic      [3:0]               buffer_pending_queue_o,
    output logic                          read_in_progress_o,
    output logic                          init_done_o,
    output logic                          core_busy_o,
    output logic                          cache_write_data_ready_o,
    output logic                          first_word_delay_one_o,
    output logic                          first_word_delay_two_o,
    output logic                          first_parity_en_o,
    output logic                          memory_to_cache_mux_o,
    output logic                          first_cache_write_o,
    output logic                          cache_buffer_cycle_o,
    output logic      [1:0]               cache_buffer_index_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    crws_state_t                 state_ff;
    crws_state_t                 nxt_state;
    crws_word_vec_t              valid_pulse_shift_reg_ff;
    crws_word_vec_t              nxt_valid_pulse_shift_reg;
    crws_idx_t                   idx_ff;
    crws_idx_t                   nxt_idx;
    crws_word_vec_t              req_lines_ff;
    crws_idx_t                   start_addr_ff;
    logic                        rip_ff;
    logic                        init_done_ff;
    logic                        proc_req_ff;
    logic                        enable_ff;
    logic [2:0]                  lclk_sync_ff;
    logic [1:0]                  va_sync_ff;
    logic [1:0]                  vb_sync_ff;
    logic                        dv1_ff;
    logic                        dv2_ff;
    logic [3:0]                  load_ff;
    logic [3:0]                  pend_ff;
    logic                        fw_ready_ff;
    logic                        fw_dly1_ff;
    logic                        fw_dly2_ff;
    logic                        fw_window_ff;
    logic                        fw_wait_ff;
    logic                        fw_write_ff;
    logic                        fw_pend_idx_valid_ff;
    crws_idx_t                   fw_idx_ff;
    logic                        bufcyc_ff;
    crws_idx_t                   bufcyc_idx_ff;
    logic [`CRWS_DATA_W-1:0]     rdata_ff;
    logic                        busy_ff;

    // ****************************************************************
    // Start decode
    // ****************************************************************
    // Pattern chosen by request kind
    wire crws_word_vec_t word_request_pattern =
        use_single_word_i ? read_single_word_i : read_invalid_words_i;
    // First requested word in ascending order
    wire crws_idx_t first_req_idx =
        word_request_pattern[0] ? 2'h0 :
        word_request_pattern[1] ? 2'h1 :
        word_request_pattern[2] ? 2'h2 : 2'h3;
    wire crws_idx_t start_addr =
        start_by_processor_i ? physical_word_bits_i : first_req_idx;
    // A start while a read is still open is ignored rather than corrupting it
    wire start_ok = read_start_i && enable_ff && (state_ff == CRWS_IDLE);

    // ****************************************************************
    // Link sampling
    // ****************************************************************
    // Link clock edges found from the second and third stages only
    wire link_rise = lclk_sync_ff[1] && !lclk_sync_ff[2];
    wire link_fall = !lclk_sync_ff[1] && lclk_sync_ff[2];
    // Phase A counted on rising link edge, phase B on falling edge
    wire strobe_seen = (link_rise && va_sync_ff[1]) || (link_fall && vb_sync_ff[1]);
    wire strobe_take = strobe_seen && rip_ff;
    // Final word: last request at top and nothing behind it
    wire last_word = (valid_pulse_shift_reg_ff == 4'h8);
    wire lead_zero = (state_ff == CRWS_RUN) && !valid_pulse_shift_reg_ff[0]
                     && (valid_pulse_shift_reg_ff != 4'h0) && !dv2_ff;
    wire [3:0] idx_onehot = 4'h1 << idx_ff;
    wire [3:0] word_arriving = strobe_take ? idx_onehot : 4'h0;
    wire first_trigger = dv2_ff && proc_req_ff;
    wire fw_active = fw_ready_ff || fw_dly1_ff || fw_dly2_ff;
    wire fw_taken = fw_wait_ff && processor_sync_strobe_i;

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    wire sel_ctrl   = (reg_addr_i == `CRWS_OFF_CTRL);
    wire sel_status = (reg_addr_i == `CRWS_OFF_STATUS);
    wire [`CRWS_ST_FILL_W-1:0] st_fill = '0;
    wire [`CRWS_DATA_W-1:0] status_word =
        {st_fill, req_lines_ff, pend_ff, valid_pulse_shift_reg_ff,
         2'h0, idx_ff, proc_req_ff, (state_ff == CRWS_INIT), busy_ff, rip_ff};
    wire [`CRWS_DATA_W-1:0] ctrl_word = {31'h0, enable_ff};
    wire [`CRWS_DATA_W-1:0] nxt_rdata =
        !reg_rd_i  ? 32'h0 :
        sel_ctrl   ? ctrl_word :
        sel_status ? status_word : 32'h0;

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_valid_pulse_shift_reg = valid_pulse_shift_reg_ff;
        nxt_idx = idx_ff;
        unique case (state_ff)
            CRWS_IDLE:
            begin
                if (start_ok)
                begin
                    nxt_valid_pulse_shift_reg = word_request_pattern;
                    nxt_idx = start_addr;
                    nxt_state = CRWS_INIT;
                end
            end
            CRWS_INIT:
            begin
                if (idx_ff != 2'h0)
                begin
                    // Rotate once per decrement
                    nxt_valid_pulse_shift_reg =
                        {valid_pulse_shift_reg_ff[1:3], valid_pulse_shift_reg_ff[0]};
                    nxt_idx = idx_ff - 2'h1;
                end
                else
                begin
                    nxt_idx = start_addr_ff;
                    nxt_state = CRWS_RUN;
                end
            end
            CRWS_RUN:
            begin
                if (dv2_ff)
                begin
                    // Load state: consume request, point at next buffer
                    nxt_valid_pulse_shift_reg = {valid_pulse_shift_reg_ff[1:3], 1'b0};
                    nxt_idx = idx_ff + 2'h1;
                    if (!rip_ff && !dv1_ff)
                    begin
                        nxt_state = CRWS_IDLE;
                    end
                end
                else if (lead_zero)
                begin
                    nxt_valid_pulse_shift_reg = {valid_pulse_shift_reg_ff[1:3], 1'b0};
                    nxt_idx = idx_ff + 2'h1;
                end
            end
        endcase
    end

    // ****************************************************************
    // Sequencer registers
    // ****************************************************************
    // Tracker, index and phase
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= CRWS_IDLE;
            valid_pulse_shift_reg_ff <= 4'h0;
            idx_ff <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            valid_pulse_shift_reg_ff <= nxt_valid_pulse_shift_reg;
            idx_ff <= nxt_idx;
        end
    end

    // Bus request lines held for the whole read
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            req_lines_ff <= 4'h0;
            start_addr_ff <= 2'h0;
        end
        else if (start_ok)
        begin
            req_lines_ff <= word_request_pattern;
            start_addr_ff <= start_addr;
        end
    end

    // In-progress flag: set at end of init, cleared by final strobe
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rip_ff <= 1'b0;
            init_done_ff <= 1'b0;
        end
        else
        begin
            init_done_ff <= (state_ff == CRWS_INIT) && (idx_ff == 2'h0);
            if ((state_ff == CRWS_INIT) && (idx_ff == 2'h0))
            begin
                rip_ff <= 1'b1;
            end
            else if (strobe_take && last_word && !lead_zero)
            begin
                rip_ff <= 1'b0;
            end
        end
    end

    // Processor request stays until the first word reaches its load state
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            proc_req_ff <= 1'b0;
        end
        else if (start_ok)
        begin
            proc_req_ff <= start_by_processor_i;
        end
        else if (first_trigger)
        begin
            proc_req_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Link synchronisers
    // ****************************************************************
    // Third link clock stage exists only for edge finding
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lclk_sync_ff <= 3'h0;
            va_sync_ff <= 2'h0;
            vb_sync_ff <= 2'h0;
        end
        else
        begin
            lclk_sync_ff <= {lclk_sync_ff[1:0], link_clk_i};
            va_sync_ff <= {va_sync_ff[0], word_valid_a_i};
            vb_sync_ff <= {vb_sync_ff[0], word_valid_b_i};
        end
    end

    // ****************************************************************
    // Data valid delay and buffer load
    // ****************************************************************
    // Two delay ticks let the bus data settle before the load
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dv1_ff <= 1'b0;
            dv2_ff <= 1'b0;
            load_ff <= 4'h0;
        end
        else
        begin
            dv1_ff <= strobe_take;
            dv2_ff <= dv1_ff;
            load_ff <= dv1_ff ? idx_onehot : 4'h0;
        end
    end

    // Pending queue: arrival sets win over drain clears
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend_ff <= 4'h0;
        end
        else
        begin
            pend_ff <= (pend_ff & ~buffer_drained_i
                         & ~(fw_write_ff && fw_pend_idx_valid_ff ? (4'h1 << fw_idx_ff) : 4'h0))
                       | word_arriving;
        end
    end

    // Words other than the first processor word go to the cache through a buffer cycle
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bufcyc_ff <= 1'b0;
            bufcyc_idx_ff <= 2'h0;
        end
        else
        begin
            bufcyc_ff <= dv2_ff && !proc_req_ff;
            bufcyc_idx_ff <= idx_ff;
        end
    end

    // ****************************************************************
    // First word delivery
    // ****************************************************************
    // Three time states fire only for the first processor word
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fw_ready_ff <= 1'b0;
            fw_dly1_ff <= 1'b0;
            fw_dly2_ff <= 1'b0;
            fw_window_ff <= 1'b0;
        end
        else
        begin
            fw_ready_ff <= first_trigger;
            fw_dly1_ff <= fw_ready_ff;
            fw_dly2_ff <= fw_dly1_ff;
            // Next-cycle OR of the three states, so the window leaves a flop
            fw_window_ff <= first_trigger | fw_ready_ff | fw_dly1_ff;
        end
    end

    // Cache write waits for the processor to take the word
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fw_wait_ff <= 1'b0;
            fw_write_ff <= 1'b0;
            fw_pend_idx_valid_ff <= 1'b0;
            fw_idx_ff <= 2'h0;
        end
        else
        begin
            fw_write_ff <= fw_taken;
            fw_pend_idx_valid_ff <= fw_taken;
            if (first_trigger)
            begin
                fw_wait_ff <= 1'b1;
                fw_idx_ff <= idx_ff;
            end
            else if (fw_taken)
            begin
                fw_wait_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control register, read data and busy
    // ****************************************************************
    // Enable gates new starts only; an open read always finishes
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            enable_ff <= 1'b1;
            rdata_ff <= 32'h0;
            busy_ff <= 1'b0;
        end
        else
        begin
            if (reg_wr_i && sel_ctrl)
            begin
                enable_ff <= reg_wdata_i[`CRWS_CTRL_EN_BIT];
            end
            rdata_ff <= nxt_rdata;
            busy_ff <= (nxt_state != CRWS_IDLE) || (pend_ff != 4'h0)
                       || (word_arriving != 4'h0) || fw_wait_ff || fw_active;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata_o = rdata_ff;
    assign mem_request_lines_o = req_lines_ff;
    assign mem_low_addr_o = start_addr_ff;
    assign buffer_load_o = load_ff;
    assign buffer_pending_queue_o = pend_ff;
    assign read_in_progress_o = rip_ff;
    assign init_done_o = init_done_ff;
    assign core_busy_o = busy_ff;
    assign cache_write_data_ready_o = fw_ready_ff;
    assign first_word_delay_one_o = fw_dly1_ff;
    assign first_word_delay_two_o = fw_dly2_ff;
    assign first_parity_en_o = fw_window_ff;
    assign memory_to_cache_mux_o = fw_window_ff;
    assign first_cache_write_o = fw_write_ff;
    assign cache_buffer_cycle_o = bufcyc_ff;
    assign cache_buffer_index_o = bufcyc_idx_ff;

endmodule

// >>> verilog/crws_params.svh
// Constants for the core read word sequencer: offsets, fields, resets, timing
`ifndef CRWS_PARAMS_SVH
`define CRWS_PARAMS_SVH

// ****************************************************************
// Register port
// ****************************************************************
`define CRWS_ADDR_W          4
`define CRWS_DATA_W          32
`define CRWS_OFF_CTRL        4'h0
`define CRWS_OFF_STATUS      4'h4
`define CRWS_CTRL_RESET      32'h00000001
`define CRWS_CTRL_EN_BIT     0
`define CRWS_ST_RIP_BIT      0
`define CRWS_ST_BUSY_BIT     1
`define CRWS_ST_INIT_BIT     2
`define CRWS_ST_PROC_BIT     3
`define CRWS_ST_IDX_LSB      4
`define CRWS_ST_SR_LSB       8
`define CRWS_ST_PEND_LSB     12
`define CRWS_ST_REQ_LSB      16
`define CRWS_ST_FILL_W       12

// ****************************************************************
// Datapath widths and timing
// ****************************************************************
`define CRWS_WORDS           4
`define CRWS_IDX_W           2
`define CRWS_SYNC_STAGES     2
`define CRWS_VALID_DELAY     2

`endif

// >>> verilog/crws_pkg.sv
// Types shared by the core read word sequencer
package crws_pkg;

    // Sequencer phases of one core read
    typedef enum logic [1:0]
    {
        CRWS_IDLE,
        CRWS_INIT,
        CRWS_RUN
    } crws_state_t;

    typedef logic [0:3] crws_word_vec_t;
    typedef logic [1:0] crws_idx_t;

endpackage
